// File: dv/sfp_frame_slave_test.sv
// self-checking bench of the frame slave with a host model on the link
`timescale 1ns/100ps
`default_nettype none

module sfp_frame_slave_test;
  logic               ref_clk, nrst, link_sclk, chip_select_n, link_mosi;
  logic               link_miso_o, link_miso_oe_n, host_attention_n, boot_mode;
  logic               wake_request_n, trace_data_line, dev_ready;
  logic               pl_start, pl_kind, pl_valid, pl_end, pl_drop, resp_ready;
  logic               resp_valid = 1'b0;
  logic               resp_last;
  logic [7:0]         reset_cause_code, pl_data, resp_data;
  sfp_pkg::sfp_byte_t ans[3];
  sfp_pkg::sfp_byte_t sb, pl_last;
  int                 n_mismatch, total_checks;
  int                 ri = 0;
  int                 n_pl = 0;
  int                 n_drop = 0;

  // ****************************************
  // clock, design and host model
  // ****************************************
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  sfp_frame_slave dut_u (.ref_clk(ref_clk), .nrst(nrst), .link_sclk(link_sclk),
    .chip_select_n(chip_select_n), .link_mosi(link_mosi), .link_miso_o(link_miso_o),
    .link_miso_oe_n(link_miso_oe_n), .host_attention_n(host_attention_n),
    .wake_request_n(wake_request_n), .trace_data_line(trace_data_line),
    .reset_cause_code(reset_cause_code), .dev_ready(dev_ready), .boot_mode(boot_mode),
    .pl_start(pl_start), .pl_kind(pl_kind), .pl_data(pl_data), .pl_valid(pl_valid),
    .pl_end(pl_end), .pl_drop(pl_drop), .resp_data(resp_data), .resp_valid(resp_valid),
    .resp_last(resp_last), .resp_ready(resp_ready));

  sfp_host_model host_u (.link_sclk(link_sclk), .chip_select_n(chip_select_n),
    .link_mosi(link_mosi), .link_miso_o(link_miso_o));

  // ****************************************
  // user answer side
  // ****************************************
  // answers a good payload frame with three bytes, counts network bytes and drops
  initial ans = '{8'hFE, 8'h01, 8'h5A};
  assign resp_data = ans[ri];
  assign resp_last = (ri == 2);
  always @(posedge ref_clk) begin
    if (pl_valid && !pl_kind) n_pl <= n_pl + 1;
    if (pl_valid) pl_last <= pl_data;
    if (pl_drop) n_drop <= n_drop + 1;
    if (pl_end) resp_valid <= 1'b1;
    else if (resp_valid && resp_ready) begin
      if (resp_last) resp_valid <= 1'b0;
      ri <= resp_last ? 0 : ri + 1;
    end
  end

  // ****************************************
  // bench tasks
  // ****************************************
  task automatic chk(input sfp_pkg::sfp_byte_t seen, input sfp_pkg::sfp_byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // reset with chosen strap levels, straps held past attention
  task automatic rst(input logic [1:0] strap_n);
    @(negedge ref_clk);
    nrst            = 1'b0;
    wake_request_n  = strap_n[1];
    trace_data_line = strap_n[0];
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (16) @(negedge ref_clk);
    wake_request_n  = 1'b1;
    trace_data_line = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask : rst

  // send a command, poll filler until the answer starts, compare the answer
  task automatic txn(input sfp_pkg::sfp_byte_t c[$], input sfp_pkg::sfp_byte_t e[$]);
    sfp_pkg::sfp_byte_t r;
    int                 k;
    host_u.sel(1'b1);
    foreach (c[i]) host_u.xfer(c[i], r);
    k = 0;
    r = 8'hFF;
    while (r === 8'hFF && k < 40) begin
      host_u.xfer(8'hFF, r);
      k++;
    end
    if (r === 8'hFF) begin
      n_mismatch++;
      close_out();
    end
    chk(r, e[0]);
    for (int i = 1; i < e.size(); i++) begin
      host_u.xfer(8'hFF, r);
      chk(r, e[i]);
    end
    host_u.sel(1'b0);
    #200;
  endtask : txn

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst = 1'b0; wake_request_n = 1'b1; trace_data_line = 1'b1; dev_ready = 1'b1;
    reset_cause_code = 8'h3C;
    n_mismatch = 0; total_checks = 0;
    rst(2'h3);
    chk({7'h00, host_attention_n}, 8'h00);
    chk({7'h00, boot_mode}, 8'h00);
    txn('{8'h0A, 8'hA7}, '{8'h00, 8'h3C, 8'hA7});
    chk({7'h00, host_attention_n}, 8'h01);
    txn('{8'h0A, 8'hA7}, '{8'h82, 8'hA7});
    txn('{8'h0B, 8'hA7}, '{8'hC1, 8'hA7});
    dev_ready = 1'b0;
    txn('{8'h0B, 8'hA7}, '{8'hC0, 8'hA7});
    txn('{8'h55, 8'hA7}, '{8'h04, 8'h00, 8'hA7});
    txn('{8'hFE, 8'h86, 8'hA7}, '{8'h01, 8'h00, 8'hA7});
    txn('{8'hFE, 8'h01, 8'h11, 8'hA7}, '{8'h04, 8'h00, 8'hA7});
    txn('{8'hFE, 8'h02, 8'h11, 8'h22, 8'h55}, '{8'h03, 8'h00, 8'hA7});
    txn('{8'hFE, 8'h02, 8'h11, 8'h22, 8'hA7}, '{8'hFE, 8'h01, 8'h5A, 8'hA7});
    chk(n_pl[7:0], 8'h04);
    chk(pl_last, 8'h22);
    txn('{8'hFD, 8'h01, 8'h33, 8'hA7}, '{8'hFE, 8'h01, 8'h5A, 8'hA7});
    chk(pl_last, 8'h33);
    chk(n_pl[7:0], 8'h04);
    host_u.sel(1'b1);
    chk({7'h00, link_miso_oe_n}, 8'h00);
    host_u.xfer(8'hFE, sb);
    chk(sb, 8'hFF);
    host_u.sel(1'b0);
    #200;
    chk(n_drop[7:0], 8'h04);
    txn('{8'h0A, 8'hA7}, '{8'h02, 8'h00, 8'hA7});
    txn('{8'h0A, 8'hA7}, '{8'h82, 8'hA7});
    host_u.sel(1'b1);
    rst(2'h2);
    chk({7'h00, boot_mode}, 8'h01);
    host_u.xfer(8'h0B, sb);
    chk(sb, 8'hFF);
    host_u.sel(1'b0);
    #200;
    txn('{8'h0B, 8'hA7}, '{8'h00, 8'h3C, 8'hA7});
    rst(2'h1);
    chk({7'h00, boot_mode}, 8'h01);
    close_out();
  end

  // hang guard
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule : sfp_frame_slave_test

`default_nettype wire

// File: dv/sfp_host_model.sv
// host side link master model for the frame slave bench
`timescale 1ns/100ps
`default_nettype none

module sfp_host_model (
  output var  logic link_sclk,
  output var  logic chip_select_n,
  output var  logic link_mosi,
  input  wire logic link_miso_o
);
  // ****************************************
  // link idle state
  // ****************************************
  // clock stands still and select idles high outside frames
  initial begin
    link_sclk     = 1'b0;
    chip_select_n = 1'b1;
    link_mosi     = 1'b0;
  end

  // ****************************************
  // host actions
  // ****************************************
  // select or release; released data line shows the inverse bit, no stale value
  task automatic sel(input logic on);
    #37;
    chip_select_n = ~on;
    if (!on) link_mosi = ~link_mosi;
    #43;
  endtask : sel

  // one byte each way, msb first, change on low phase, sample on rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      link_mosi = tx[i];
      #20 link_sclk = 1'b1;
      rx[i] = link_miso_o;
      #40 link_sclk = 1'b0;
      #20;
    end
  endtask : xfer
endmodule : sfp_host_model

`default_nettype wire

// File: hw/sfp_defines.svh
// constants of the serial frame protocol slave
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH

// ****************************************
// frame type, filler and end marker bytes
// ****************************************
`define SFP_T_VER        8'h0A
`define SFP_T_STAT       8'h0B
`define SFP_T_BOOT       8'hFD
`define SFP_T_NET        8'hFE
`define SFP_FILL         8'hFF
`define SFP_EOF          8'hA7

// ****************************************
// answer fields
// ****************************************
`define SFP_VERSION      6'h02
`define SFP_VER_TAG      2'h2
`define SFP_STAT_TAG     2'h3
`define SFP_STAT_PAD     5'h00
`define SFP_E_RESET      8'h00
`define SFP_E_OVER       8'h01
`define SFP_E_ABORT      8'h02
`define SFP_E_NOTERM     8'h03
`define SFP_E_UNSUP      8'h04
`define SFP_E_DETAIL     8'h00

// ****************************************
// length limits, counts and attention reset level
// ****************************************
`define SFP_LEN_MAX      8'h85
`define SFP_LEN_MIN_BOOT 8'h01
`define SFP_LEN_MIN_NET  8'h02
`define SFP_IDX_SHORT    2'h1
`define SFP_IDX_LONG     2'h2
`define SFP_STRAP_WAIT   2'h3
`define SFP_ATTN_RST     1'h0

`endif

// File: hw/sfp_frame_slave.sv
// device end of the framed serial host link
// Notes on behaviour
// (RULE1) version query answers bit7 set, bit6 clear, version below; here 0x82
// (RULE2) version number stays within 1 to 63
// (RULE3) status answer has top two bits set, bit0 means alive and ready
// (RULE4) boot frame type is followed by length; at least four bytes
// (RULE5) network frame type is followed by length; at least five bytes
// (RULE6) only codes 0x00 to 0x04 are errors; pending error overrides command
// (RULE7) every error answer carries a detail byte in the length position
// (RULE8) length above 133 drops command, answers oversize code
// (RULE9) unfinished transaction answers aborted code
// (RULE10) missing end marker drops command, answers missing-marker code
// (RULE11) unknown frame type drops command, answers unsupported code
// (RULE12) attention asserts after any reset
// (RULE13) first transaction after reset answers reset code then reset cause
// (RULE14) attention drops after a byte arrives; later commands run normally
// (RULE15) host does the wake handshake after its own power up
// (RULE16) wake or trace line low at reset release selects boot mode
// (RULE17) host holds strap line low until attention asserts
// (RULE18) select going idle re-initialises the protocol machine
// (RULE19) after reset traffic is ignored until select goes idle; code leaves SYNC the cycle after release, select sync resets idle
// (RULE20) a host that resets should also reset the device
// (RULE21) host discards answers cut by a device reset
// (RULE22) every frame ends with marker 0xA7 not counted in length
// (RULE23) host never sends more than 136 bytes
// (RULE24) host polls filler bytes until a non-filler byte
// (RULE25) filler 0xFF is driven while no answer byte is ready
`timescale 1ns/100ps
`default_nettype none
`include "sfp_defines.svh"

module sfp_frame_slave (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       link_sclk,
  input  wire logic       chip_select_n,
  input  wire logic       link_mosi,
  output var  logic       link_miso_o,
  output logic            link_miso_oe_n,
  output var  logic       host_attention_n,
  input  wire logic       wake_request_n,
  input  wire logic       trace_data_line,
  input  wire logic [7:0] reset_cause_code,
  input  wire logic       dev_ready,
  output var  logic       boot_mode,
  output var  logic       pl_start,
  output var  logic       pl_kind,
  output var  logic [7:0] pl_data,
  output var  logic       pl_valid,
  output var  logic       pl_end,
  output var  logic       pl_drop,
  input  wire logic [7:0] resp_data,
  input  wire logic       resp_valid,
  input  wire logic       resp_last,
  output logic            resp_ready
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic sfp_is_pl(input logic [7:0] t);
    return (t == `SFP_T_BOOT) || (t == `SFP_T_NET);
  endfunction : sfp_is_pl

  function automatic logic [7:0] sfp_len_min(input logic [7:0] t);
    return (t == `SFP_T_BOOT) ? `SFP_LEN_MIN_BOOT : `SFP_LEN_MIN_NET;
  endfunction : sfp_len_min

  logic                  rst_m_q, rst_n_q;
  logic                  cs_m_q, cs_s_q, tg_m_q, tg_s_q, tg_d_q;
  logic                  wk_m_q, wk_s_q, td_m_q, td_s_q;
  logic [1:0]            strap_q;
  logic [7:0]            cause_q;
  logic [7:0]            rx_byte;
  logic                  rx_tgl;
  logic                  evt, cs_idle, abort, cmd_busy;
  sfp_pkg::sfp_state_t   state_q, state_d;
  logic                  fin, fin_err;
  sfp_pkg::sfp_byte_t    fin_code;
  sfp_pkg::sfp_byte_t    type_q, len_q, cnt_q, tx_q, b0_q, b1_q;
  logic [1:0]            idx_q, last_q;
  logic                  rst_pend_q, err_pend_q, set_attn, clr_attn;
  sfp_pkg::sfp_byte_t    err_q;

  // ****************************************
  // reset release and synchronisers
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // pins and link toggle enter through two flops
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      tg_m_q <= 1'b0;
      tg_s_q <= 1'b0;
      tg_d_q <= 1'b0;
      wk_m_q <= 1'b1;
      wk_s_q <= 1'b1;
      td_m_q <= 1'b1;
      td_s_q <= 1'b1;
    end else begin
      cs_m_q <= chip_select_n;
      cs_s_q <= cs_m_q;
      tg_m_q <= rx_tgl;
      tg_s_q <= tg_m_q;
      tg_d_q <= tg_s_q;
      wk_m_q <= wake_request_n;
      wk_s_q <= wk_m_q;
      td_m_q <= trace_data_line;
      td_s_q <= td_m_q;
    end
  end

  assign cs_idle = cs_s_q;
  assign evt     = (tg_s_q ^ tg_d_q) & ~cs_s_q;

  // ****************************************
  // boot strap capture after reset release
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strap_q   <= 2'h0;
      boot_mode <= 1'b0;
      cause_q   <= 8'h00;
    end else if (strap_q != `SFP_STRAP_WAIT) begin
      strap_q <= strap_q + 2'h1;
      if (strap_q + 2'h1 == `SFP_STRAP_WAIT) begin
        boot_mode <= ~wk_s_q | ~td_s_q; // RULE16
        cause_q   <= reset_cause_code;
      end
    end
  end

  // ****************************************
  // link side
  // ****************************************
  sfp_link_shifter u_shift (
    .sclk_link     (link_sclk),
    .chip_select_n (chip_select_n),
    .link_mosi     (link_mosi),
    .rst_n         (rst_n_q),
    .tx_word       (tx_q),
    .rx_byte       (rx_byte),
    .rx_toggle     (rx_tgl),
    .link_miso     (link_miso_o)
  );

  // output driven while selected
  assign link_miso_oe_n = chip_select_n;

  // ****************************************
  // protocol state machine
  // ****************************************
  assign cmd_busy = (state_q == sfp_pkg::SFP_LEN) || (state_q == sfp_pkg::SFP_BODY) ||
                    (state_q == sfp_pkg::SFP_TERM);
  assign abort    = cs_idle && (cmd_busy || state_q == sfp_pkg::SFP_RESP ||
                    state_q == sfp_pkg::SFP_USER);

  // next state and end-of-command decision
  always_comb begin
    state_d  = state_q;
    fin      = 1'b0;
    fin_err  = 1'b0;
    fin_code = `SFP_E_DETAIL;
    case (state_q)
      sfp_pkg::SFP_SYNC: begin
      end
      sfp_pkg::SFP_IDLE: begin
        if (!cs_idle) state_d = sfp_pkg::SFP_TYPE;
      end
      sfp_pkg::SFP_TYPE: begin
        if (evt) begin
          if (rx_byte == `SFP_T_VER || rx_byte == `SFP_T_STAT) begin
            state_d = sfp_pkg::SFP_TERM;
          end else if (sfp_is_pl(rx_byte)) begin
            state_d = sfp_pkg::SFP_LEN; // RULE4 RULE5
          end else begin
            fin      = 1'b1;
            fin_err  = 1'b1;
            fin_code = `SFP_E_UNSUP; // RULE11
          end
        end
      end
      sfp_pkg::SFP_LEN: begin
        if (evt) begin
          if (rx_byte > `SFP_LEN_MAX) begin
            fin      = 1'b1;
            fin_err  = 1'b1;
            fin_code = `SFP_E_OVER; // RULE8
          end else if (rx_byte < sfp_len_min(type_q)) begin
            fin      = 1'b1;
            fin_err  = 1'b1;
            fin_code = `SFP_E_UNSUP; // RULE4 RULE5
          end else begin
            state_d = sfp_pkg::SFP_BODY;
          end
        end
      end
      sfp_pkg::SFP_BODY: begin
        if (evt && cnt_q + 8'h01 == len_q) state_d = sfp_pkg::SFP_TERM;
      end
      sfp_pkg::SFP_TERM: begin
        if (evt) begin
          fin = 1'b1;
          if (rx_byte != `SFP_EOF) begin
            fin_err  = 1'b1;
            fin_code = `SFP_E_NOTERM; // RULE10
          end
        end
      end
      sfp_pkg::SFP_RESP: begin
        if (evt && idx_q == last_q) state_d = sfp_pkg::SFP_DONE;
      end
      sfp_pkg::SFP_USER: begin
        if (evt && resp_valid && resp_last) state_d = sfp_pkg::SFP_RESP;
      end
      sfp_pkg::SFP_DONE: begin
      end
      default: state_d = sfp_pkg::SFP_SYNC;
    endcase
    if (fin) begin
      state_d = (rst_pend_q || err_pend_q || fin_err || !sfp_is_pl(type_q)) ?
                sfp_pkg::SFP_RESP : sfp_pkg::SFP_USER; // RULE6 RULE13
    end
    if (cs_idle) state_d = sfp_pkg::SFP_IDLE; // RULE18 RULE19
  end

  // state register, starts waiting for an idle select
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) state_q <= sfp_pkg::SFP_SYNC; // RULE19
    else          state_q <= state_d;
  end

  // command fields
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      type_q <= `SFP_FILL;
      len_q  <= 8'h00;
      cnt_q  <= 8'h00;
    end else if (evt) begin
      if (state_q == sfp_pkg::SFP_TYPE) type_q <= rx_byte;
      if (state_q == sfp_pkg::SFP_LEN) begin
        len_q <= rx_byte;
        cnt_q <= 8'h00;
      end
      if (state_q == sfp_pkg::SFP_BODY) cnt_q <= cnt_q + 8'h01;
    end
  end

  // ****************************************
  // pending reset and error reports
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rst_pend_q <= 1'b1;
      err_pend_q <= 1'b0;
      err_q      <= `SFP_E_ABORT;
    end else begin
      if (fin) rst_pend_q <= 1'b0;
      if (abort) begin
        err_pend_q <= 1'b1; // RULE9
        err_q      <= `SFP_E_ABORT;
      end else if (fin && !rst_pend_q) begin
        err_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // answer bytes
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      b0_q   <= `SFP_FILL;
      b1_q   <= `SFP_FILL;
      idx_q  <= 2'h0;
      last_q <= `SFP_IDX_LONG;
    end else if (fin) begin
      idx_q  <= 2'h0;
      last_q <= `SFP_IDX_LONG;
      b1_q   <= `SFP_E_DETAIL; // RULE7
      if (rst_pend_q) begin
        b0_q <= `SFP_E_RESET; // RULE13
        b1_q <= cause_q;
      end else if (err_pend_q) begin
        b0_q <= err_q; // RULE6
      end else if (fin_err) begin
        b0_q <= fin_code;
      end else if (type_q == `SFP_T_VER) begin
        b0_q   <= {`SFP_VER_TAG, `SFP_VERSION}; // RULE1 RULE2
        b1_q   <= `SFP_EOF;
        last_q <= `SFP_IDX_SHORT;
      end else if (type_q == `SFP_T_STAT) begin
        b0_q   <= {`SFP_STAT_TAG, `SFP_STAT_PAD, dev_ready}; // RULE3
        b1_q   <= `SFP_EOF;
        last_q <= `SFP_IDX_SHORT;
      end
    end else if (state_q == sfp_pkg::SFP_USER && evt && resp_valid && resp_last) begin
      idx_q  <= `SFP_IDX_LONG;
      last_q <= `SFP_IDX_LONG;
    end else if (state_q == sfp_pkg::SFP_RESP && evt) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  // word handed to the link, used two bytes later
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_q <= `SFP_FILL;
    end else if (cs_idle) begin
      tx_q <= `SFP_FILL;
    end else if (evt) begin
      if (state_q == sfp_pkg::SFP_RESP) begin
        tx_q <= (idx_q == 2'h0) ? b0_q : (idx_q == 2'h1) ? b1_q : `SFP_EOF; // RULE22
      end else if (state_q == sfp_pkg::SFP_USER && resp_valid) begin
        tx_q <= resp_data;
      end else begin
        tx_q <= `SFP_FILL; // RULE25
      end
    end
  end

  assign resp_ready = (state_q == sfp_pkg::SFP_USER) && evt;

  // ****************************************
  // host attention
  // ****************************************
  assign set_attn = abort || (fin && state_d == sfp_pkg::SFP_RESP) ||
                    (state_q == sfp_pkg::SFP_USER && resp_valid && !evt);
  assign clr_attn = evt && (state_q == sfp_pkg::SFP_TYPE ||
                    (state_q == sfp_pkg::SFP_RESP && idx_q == 2'h0) ||
                    (state_q == sfp_pkg::SFP_USER && resp_valid));

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q)      host_attention_n <= `SFP_ATTN_RST; // RULE12
    else if (set_attn) host_attention_n <= 1'b0;
    else if (clr_attn) host_attention_n <= 1'b1; // RULE14
  end

  // ****************************************
  // payload stream to the user side
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pl_start <= 1'b0;
      pl_kind  <= 1'b0;
      pl_data  <= 8'h00;
      pl_valid <= 1'b0;
      pl_end   <= 1'b0;
      pl_drop  <= 1'b0;
    end else begin
      pl_start <= evt && state_q == sfp_pkg::SFP_LEN && state_d == sfp_pkg::SFP_BODY;
      pl_kind  <= (type_q == `SFP_T_BOOT);
      pl_valid <= evt && state_q == sfp_pkg::SFP_BODY;
      pl_data  <= rx_byte;
      pl_end   <= fin && !fin_err && sfp_is_pl(type_q) && !rst_pend_q;
      pl_drop  <= sfp_is_pl(type_q) && cmd_busy && (abort || fin_err); // RULE8 RULE10
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_q);

  sequence s_clean_fin;
    fin && !rst_pend_q && !err_pend_q;
  endsequence

  sequence s_ver_done;
    s_clean_fin ##0 (state_q == sfp_pkg::SFP_TERM && !fin_err && type_q == `SFP_T_VER);
  endsequence

  a_ver_answer: assert property ( // RULE1
    s_ver_done |=> b0_q[7:6] == `SFP_VER_TAG && b0_q[5:0] == `SFP_VERSION
    ##1 (state_q == sfp_pkg::SFP_RESP && last_q == `SFP_IDX_SHORT))
    else $error("version answer wrong");

  a_ver_range: assert property ( // RULE2
    state_q == sfp_pkg::SFP_RESP && type_q == `SFP_T_VER && last_q == `SFP_IDX_SHORT
    |-> b0_q[5:0] != 6'h00) else $error("version out of range");

  a_stat_answer: assert property ( // RULE3
    s_clean_fin ##0 (!fin_err && type_q == `SFP_T_STAT)
    |=> b0_q[7:6] == `SFP_STAT_TAG && b0_q[0] == $past(dev_ready))
    else $error("status answer wrong");

  a_len_minimum: assert property ( // RULE5
    evt && state_q == sfp_pkg::SFP_LEN && type_q == `SFP_T_NET && rx_byte < `SFP_LEN_MIN_NET
    |-> fin_err) else $error("short network frame accepted");

  a_pend_error: assert property ( // RULE6
    fin && err_pend_q && !rst_pend_q |=> b0_q == $past(err_q) && b0_q <= `SFP_E_UNSUP)
    else $error("pending error not answered");

  a_err_detail: assert property ( // RULE7
    fin && fin_err && !rst_pend_q |=> b1_q == `SFP_E_DETAIL && last_q == `SFP_IDX_LONG)
    else $error("error detail missing");

  a_oversize: assert property ( // RULE8
    s_clean_fin ##0 (state_q == sfp_pkg::SFP_LEN && rx_byte > `SFP_LEN_MAX)
    |=> b0_q == `SFP_E_OVER && pl_drop) else $error("oversize not reported");

  a_abort_flag: assert property ( // RULE9
    abort |=> err_pend_q && err_q == `SFP_E_ABORT && !host_attention_n)
    else $error("abort not recorded");

  a_no_marker: assert property ( // RULE10
    s_clean_fin ##0 (state_q == sfp_pkg::SFP_TERM && rx_byte != `SFP_EOF)
    |=> b0_q == `SFP_E_NOTERM) else $error("missing marker not reported");

  a_unsupported: assert property ( // RULE11
    s_clean_fin ##0 (state_q == sfp_pkg::SFP_TYPE)
    |=> b0_q == `SFP_E_UNSUP && state_q == sfp_pkg::SFP_RESP)
    else $error("unknown type not reported");

  a_reset_attn: assert property ( // RULE12
    rst_pend_q && state_q == sfp_pkg::SFP_SYNC |-> !host_attention_n)
    else $error("attention not raised after reset");

  a_reset_first: assert property ( // RULE13
    fin && rst_pend_q |=> b0_q == `SFP_E_RESET && b1_q == cause_q && !rst_pend_q)
    else $error("reset answer wrong");

  a_attn_clear: assert property ( // RULE14
    evt && state_q == sfp_pkg::SFP_TYPE && !fin |=> host_attention_n)
    else $error("attention kept after byte");

  a_select_idle: assert property ( // RULE18
    cs_idle && state_q != sfp_pkg::SFP_SYNC |=> state_q == sfp_pkg::SFP_IDLE)
    else $error("idle select did not reinit");

  a_sync_hold: assert property ( // RULE19
    state_q == sfp_pkg::SFP_SYNC && !cs_idle |=> state_q == sfp_pkg::SFP_SYNC)
    else $error("traffic taken before idle");

  a_end_marker: assert property ( // RULE22
    evt && state_q == sfp_pkg::SFP_RESP && idx_q == last_q |=> tx_q == `SFP_EOF)
    else $error("marker not last");

  a_filler: assert property ( // RULE25
    evt && state_q == sfp_pkg::SFP_USER && !resp_valid |=> tx_q == `SFP_FILL)
    else $error("filler not driven");

endmodule : sfp_frame_slave
`default_nettype wire

// File: hw/sfp_link_shifter.sv
// serial shifter running on the link clock
`timescale 1ns/100ps
`default_nettype none
`include "sfp_defines.svh"

module sfp_link_shifter (
  input  wire logic       sclk_link,
  input  wire logic       chip_select_n,
  input  wire logic       link_mosi,
  input  wire logic       rst_n,
  input  wire logic [7:0] tx_word,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_toggle,
  output var  logic       link_miso
);

  logic [2:0] bit_q;
  logic [6:0] rx_sh_q;
  logic [7:0] tx_sh_q;

  // ****************************************
  // bit counter and shift registers
  // ****************************************
  // idle select clears the byte position
  always_ff @(posedge sclk_link or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_q   <= 3'h0;
      rx_sh_q <= 7'h00;
      tx_sh_q <= `SFP_FILL;
    end else begin
      bit_q   <= bit_q + 3'h1;
      rx_sh_q <= {rx_sh_q[5:0], link_mosi};
      // next byte taken on the edge that also flags the received one
      if (bit_q == 3'h7) begin
        tx_sh_q <= tx_word;
      end else begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b1};
      end
    end
  end

  // received byte and its event toggle
  always_ff @(posedge sclk_link or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte   <= 8'h00;
      rx_toggle <= 1'b0;
    end else if (!chip_select_n && bit_q == 3'h7) begin
      rx_byte   <= {rx_sh_q, link_mosi};
      rx_toggle <= ~rx_toggle;
    end
  end

  // output bit changes on the falling edge
  always_ff @(negedge sclk_link or posedge chip_select_n) begin
    if (chip_select_n) begin
      link_miso <= 1'b1;
    end else begin
      link_miso <= tx_sh_q[7];
    end
  end

endmodule : sfp_link_shifter
`default_nettype wire

// File: hw/sfp_pkg.sv
// types of the serial frame protocol slave
package sfp_pkg;

  // protocol states, gray along command, answer, done
  typedef enum logic [3:0] {
    SFP_SYNC = 4'h0,
    SFP_IDLE = 4'h1,
    SFP_TYPE = 4'h3,
    SFP_LEN  = 4'h2,
    SFP_BODY = 4'h6,
    SFP_TERM = 4'h7,
    SFP_RESP = 4'h5,
    SFP_USER = 4'h4,
    SFP_DONE = 4'hC
  } sfp_state_t;

  typedef logic [7:0] sfp_byte_t;

endpackage : sfp_pkg
